// ---- verilog/gfcm_defines.vh ----
// gfcm_defines.vh: constants shared by the glitch-free clock mux and gate block
// assumes inclusion by bare name from files under verilog/
`ifndef GFCM_DEFINES_VH
`define GFCM_DEFINES_VH

// idle (parked) output level of each multiplexer variant
`define GFCM_IDLE_RISE   1'b0
`define GFCM_IDLE_FALL   1'b1

// source index: clk_in_low_sel or clk_in_high_sel
`define GFCM_SRC_LOW     1'b0
`define GFCM_SRC_HIGH    1'b1

// multiplexer state codes
`define GFCM_ST_RUN      1'b0
`define GFCM_ST_HOLD     1'b1

// reset value of the synchroniser stages
`define GFCM_SYNC_RST    9'h000

// width of the synchronised input bundle and bit index of each input
`define GFCM_SYNC_W      9
`define GFCM_B_RMUX_LO   0
`define GFCM_B_RMUX_HI   1
`define GFCM_B_RMUX_SEL  2
`define GFCM_B_FMUX_LO   3
`define GFCM_B_FMUX_HI   4
`define GFCM_B_FMUX_SEL  5
`define GFCM_B_RGATE_CLK 6
`define GFCM_B_FGATE_CLK 7
`define GFCM_B_GBUF_CLK  8

// constant ties of the gated buffers' unused clock input
`define GFCM_TIE_ZERO    1'b0
`define GFCM_TIE_ONE     1'b1

`endif

// ---- verilog/gfcm_mux_core.v ----
// gfcm_mux_core: one glitch-free two-input clock multiplexer, sampled on the core clock
// assumes all inputs are already synchronised and filtered in the core clock domain
`timescale 1ns/1ps
`include "gfcm_defines.vh"

module gfcm_mux_core #(
   parameter [0:0] IDLE_LVL = `GFCM_IDLE_RISE
) (
   // clock and reset
   input  wire i_core_clk,
   input  wire i_rst_n,
   // filtered clock inputs and select
   input  wire i_clk_low_sel,
   input  wire i_clk_high_sel,
   input  wire i_select,
   // muxed clock and status
   output reg  o_clk,
   output reg  o_src,
   output reg  o_hold
);

   localparam [0:0] ST_RUN  = `GFCM_ST_RUN;
   localparam [0:0] ST_HOLD = `GFCM_ST_HOLD;

   reg        state_r;
   reg        state_nxt;
   reg        src_nxt;
   reg        out_nxt;
   reg  [1:0] prev_r;
   wire [1:0] clk_vec;
   wire       cur_clk;
   wire       tgt_clk;
   wire       tgt_prev;

   assign clk_vec  = {i_clk_high_sel, i_clk_low_sel};
   assign cur_clk  = clk_vec[o_src];
   assign tgt_clk  = clk_vec[~o_src];
   assign tgt_prev = prev_r[~o_src];

   // switch-over decision
   always @* begin
      state_nxt = state_r;
      src_nxt   = o_src;
      out_nxt   = IDLE_LVL;
      case (state_r)
         ST_RUN: begin
            out_nxt = cur_clk;
            // select only looked at while the old clock is parked
            if ((i_select != o_src) && (cur_clk == IDLE_LVL)) begin
               state_nxt = ST_HOLD;
               out_nxt   = IDLE_LVL;
            end
         end
         ST_HOLD: begin
            out_nxt = IDLE_LVL;
            if ((i_select == o_src) && (cur_clk == IDLE_LVL)) begin
               state_nxt = ST_RUN;                          // switch withdrawn, old phase continues
            end else if ((i_select != o_src) && (tgt_prev != IDLE_LVL) && (tgt_clk == IDLE_LVL)) begin
               state_nxt = ST_RUN;
               src_nxt   = ~o_src;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // state, source and output registers; power-up forwards the low-select input
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ST_RUN;
         o_src   <= `GFCM_SRC_LOW;
         o_clk   <= IDLE_LVL;
         o_hold  <= 1'b0;
         prev_r  <= {IDLE_LVL, IDLE_LVL};
      end else begin
         state_r <= state_nxt;
         o_src   <= src_nxt;
         o_clk   <= out_nxt;
         o_hold  <= (state_nxt == ST_HOLD);
         prev_r  <= clk_vec;
      end
   end

endmodule // gfcm_mux_core

// ---- verilog/gfcm_top.v ----
// gfcm_top: glitch-free clock multiplexers (rising and falling variant), gated clock
// buffers built on them, and a plain global clock buffer, all oversampled on i_core_clk
// assumes every clock, select and enable input is asynchronous to i_core_clk and that
// i_core_clk is well above twice the fastest input clock rate
// output clocks lag their inputs by about five core cycles and move only on core edges
// a disabled gate keeps its multiplexer parked; re-enabling resumes while the clock idles
//
// Contract
// - output follows low-select input when select low, high-select input when high.
// - output high and low phases never shorter than the shortest input phase.
// - the two inputs may be unrelated or asynchronous; switching stays safe.
// - rising variant ignores select changes while the selected clock is high.
// - falling variant ignores select changes while the selected clock is low.
// - rising variant parks low, then hands over on the new clock's fall.
// - falling variant parks high, then hands over on the new clock's rise.
// - rising gate: enable high before rising edge passes the whole pulse.
// - rising gate: enable low before rising edge blocks pulse, output stays low.
// - rising gate ignores enable while clock high; finishes high pulse first.
// - falling gate: enable high before falling edge passes the whole pulse.
// - falling gate: enable low before falling edge blocks pulse, output stays high.
// - falling gate ignores enable while clock low; finishes low pulse first.
// - each gated buffer is built on the multiplexer of matching edge polarity.
// - plain buffer reproduces its input clock unchanged.
// - rising gate: clock on low-select, zero on high-select, select is inverted enable.
// - falling gate: clock on low-select, one on high-select, select is inverted enable.
`timescale 1ns/1ps
`include "gfcm_defines.vh"

module gfcm_top (
   // core clock and reset
   input  wire i_core_clk,
   input  wire i_rst_n,
   // rising-edge multiplexer inputs
   input  wire i_rmux_clk_low_sel,
   input  wire i_rmux_clk_high_sel,
   input  wire i_rmux_clock_select,
   // falling-edge multiplexer inputs
   input  wire i_fmux_clk_low_sel,
   input  wire i_fmux_clk_high_sel,
   input  wire i_fmux_clock_select,
   // rising-edge gated buffer inputs
   input  wire i_rgate_clk,
   input  wire i_rgate_clock_gate_enable,
   // falling-edge gated buffer inputs
   input  wire i_fgate_clk,
   input  wire i_fgate_clock_gate_enable,
   // plain buffer input
   input  wire i_gbuf_clk,
   // rising-edge multiplexer outputs
   output wire o_rmux_clk,
   output wire o_rmux_src,
   output wire o_rmux_hold,
   // falling-edge multiplexer outputs
   output wire o_fmux_clk,
   output wire o_fmux_src,
   output wire o_fmux_hold,
   // gated buffer outputs
   output wire o_rgate_clk,
   output wire o_fgate_clk,
   // plain buffer output
   output reg  o_gbuf_clk
);

   reg  [`GFCM_SYNC_W-1:0] sync1_r;
   reg  [`GFCM_SYNC_W-1:0] sync2_r;
   reg  [`GFCM_SYNC_W-1:0] sync3_r;
   reg  [`GFCM_SYNC_W-1:0] filt_r;
   wire [`GFCM_SYNC_W-1:0] pins;
   reg  [`GFCM_SYNC_W-1:0] filt_nxt;
   integer                 fi;
   wire                    rgate_sel;
   wire                    fgate_sel;
   wire                    rmux_lo_f;
   wire                    rmux_hi_f;
   wire                    rmux_sel_f;
   wire                    fmux_lo_f;
   wire                    fmux_hi_f;
   wire                    fmux_sel_f;
   wire                    rgate_clk_f;
   wire                    fgate_clk_f;
   wire                    gbuf_clk_f;

   // gather asynchronous clock and select inputs; the gate enables are not in this bundle
   assign pins[`GFCM_B_RMUX_LO]   = i_rmux_clk_low_sel;
   assign pins[`GFCM_B_RMUX_HI]   = i_rmux_clk_high_sel;
   assign pins[`GFCM_B_RMUX_SEL]  = i_rmux_clock_select;
   assign pins[`GFCM_B_FMUX_LO]   = i_fmux_clk_low_sel;
   assign pins[`GFCM_B_FMUX_HI]   = i_fmux_clk_high_sel;
   assign pins[`GFCM_B_FMUX_SEL]  = i_fmux_clock_select;
   assign pins[`GFCM_B_RGATE_CLK] = i_rgate_clk;
   assign pins[`GFCM_B_FGATE_CLK] = i_fgate_clk;
   assign pins[`GFCM_B_GBUF_CLK]  = i_gbuf_clk;

   // next filtered level: take stage three once stages two and three agree, else keep the old level
   function agree_filter (
      input stage2,
      input stage3,
      input held
   );
      agree_filter = (stage2 == stage3) ? stage3 : held;
   endfunction

   // a level change counts only once stages two and three agree
   always @* begin
      filt_nxt = filt_r;
      for (fi = 0; fi < `GFCM_SYNC_W; fi = fi + 1) begin
         filt_nxt[fi] = agree_filter(sync2_r[fi], sync3_r[fi], filt_r[fi]);
      end
   end

   // filtered copies of each input, named for the path that uses them
   assign rmux_lo_f   = filt_r[`GFCM_B_RMUX_LO];
   assign rmux_hi_f   = filt_r[`GFCM_B_RMUX_HI];
   assign rmux_sel_f  = filt_r[`GFCM_B_RMUX_SEL];
   assign fmux_lo_f   = filt_r[`GFCM_B_FMUX_LO];
   assign fmux_hi_f   = filt_r[`GFCM_B_FMUX_HI];
   assign fmux_sel_f  = filt_r[`GFCM_B_FMUX_SEL];
   assign rgate_clk_f = filt_r[`GFCM_B_RGATE_CLK];
   assign fgate_clk_f = filt_r[`GFCM_B_FGATE_CLK];
   assign gbuf_clk_f  = filt_r[`GFCM_B_GBUF_CLK];

   // three-stage synchroniser with agreement filter
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_r <= `GFCM_SYNC_RST;
         sync2_r <= `GFCM_SYNC_RST;
         sync3_r <= `GFCM_SYNC_RST;
         filt_r  <= `GFCM_SYNC_RST;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r  <= filt_nxt;
      end
   end

   // gate enables are synchronised separately so the select path stays a plain level
   reg [2:0] rgate_en_sync_r;
   reg [2:0] fgate_en_sync_r;
   reg       rgate_en_r;
   reg       fgate_en_r;

   // enable synchronisers with the same agreement filter
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rgate_en_sync_r <= 3'h0;
         fgate_en_sync_r <= 3'h0;
         rgate_en_r      <= 1'b0;
         fgate_en_r      <= 1'b0;
      end else begin
         rgate_en_sync_r <= {rgate_en_sync_r[1:0], i_rgate_clock_gate_enable};
         fgate_en_sync_r <= {fgate_en_sync_r[1:0], i_fgate_clock_gate_enable};
         rgate_en_r      <= agree_filter(rgate_en_sync_r[1], rgate_en_sync_r[2], rgate_en_r);
         fgate_en_r      <= agree_filter(fgate_en_sync_r[1], fgate_en_sync_r[2], fgate_en_r);
      end
   end

   // disabled gate selects the constant input
   assign rgate_sel = ~rgate_en_r;
   assign fgate_sel = ~fgate_en_r;

   // rising-edge multiplexer
   gfcm_mux_core #(
      .IDLE_LVL       (`GFCM_IDLE_RISE)
   ) u_rmux (
      .i_core_clk     (i_core_clk),
      .i_rst_n        (i_rst_n),
      .i_clk_low_sel  (rmux_lo_f),
      .i_clk_high_sel (rmux_hi_f),
      .i_select       (rmux_sel_f),
      .o_clk          (o_rmux_clk),
      .o_src          (o_rmux_src),
      .o_hold         (o_rmux_hold)
   );

   // falling-edge multiplexer
   gfcm_mux_core #(
      .IDLE_LVL       (`GFCM_IDLE_FALL)
   ) u_fmux (
      .i_core_clk     (i_core_clk),
      .i_rst_n        (i_rst_n),
      .i_clk_low_sel  (fmux_lo_f),
      .i_clk_high_sel (fmux_hi_f),
      .i_select       (fmux_sel_f),
      .o_clk          (o_fmux_clk),
      .o_src          (o_fmux_src),
      .o_hold         (o_fmux_hold)
   );

   // rising-edge gated buffer on the rising multiplexer, parks low
   gfcm_mux_core #(
      .IDLE_LVL       (`GFCM_IDLE_RISE)
   ) u_rgate (
      .i_core_clk     (i_core_clk),
      .i_rst_n        (i_rst_n),
      .i_clk_low_sel  (rgate_clk_f),
      .i_clk_high_sel (`GFCM_TIE_ZERO),
      .i_select       (rgate_sel),
      .o_clk          (o_rgate_clk),
      .o_src          (),
      .o_hold         ()
   );

   // falling-edge gated buffer on the falling multiplexer, parks high
   gfcm_mux_core #(
      .IDLE_LVL       (`GFCM_IDLE_FALL)
   ) u_fgate (
      .i_core_clk     (i_core_clk),
      .i_rst_n        (i_rst_n),
      .i_clk_low_sel  (fgate_clk_f),
      .i_clk_high_sel (`GFCM_TIE_ONE),
      .i_select       (fgate_sel),
      .o_clk          (o_fgate_clk),
      .o_src          (),
      .o_hold         ()
   );

   // plain buffer: filtered input clock, retimed once
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gbuf_clk <= 1'b0;
      end else begin
         o_gbuf_clk <= gbuf_clk_f;
      end
   end

endmodule // gfcm_top

// ---- verif/gfcm_clk_src.sv ----
// gfcm_clk_src: free-running clock source standing in for an external clock on the mux or gate
// assumes phases are whole core cycles, so every level lasts at least four core edges
`timescale 1ns/1ps
module gfcm_clk_src #(
   parameter integer HI = 4,
   parameter integer LO = 4
) (
   // core clock and reset
   input  wire  i_core_clk,
   input  wire  i_rst_n,
   // generated clock
   output logic o_clk
);
   integer cnt;
   // unrelated periods per instance, so the two mux inputs drift against each other
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt   <= 0;
         o_clk <= 1'b0;
      end else if (cnt == (o_clk ? HI : LO) - 1) begin
         cnt   <= 0;
         o_clk <= ~o_clk;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // gfcm_clk_src

// ---- verif/gfcm_props.sv ----
// gfcm_props: port-level checks of the clock mux, gate and buffer block
// assumes input clock phases of four core cycles or more and one core clock domain
`timescale 1ns/1ps
module gfcm_props (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst_n,
   // watched ports
   input wire i_gbuf_clk,
   input wire i_rgate_clock_gate_enable,
   input wire i_fgate_clock_gate_enable,
   input wire o_rmux_clk,
   input wire o_rmux_src,
   input wire o_rmux_hold,
   input wire o_fmux_clk,
   input wire o_fmux_src,
   input wire o_fmux_hold,
   input wire o_rgate_clk,
   input wire o_fgate_clk,
   input wire o_gbuf_clk
);
   reg [4:0] rlow_r;
   reg [4:0] flow_r;
   default clocking cb_core @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // cycles each enable has been held low, saturating at 31
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rlow_r <= 5'h00;
         flow_r <= 5'h00;
      end else begin
         rlow_r <= i_rgate_clock_gate_enable ? 5'h00 : rlow_r + {4'h0, rlow_r != 5'h1f};
         flow_r <= i_fgate_clock_gate_enable ? 5'h00 : flow_r + {4'h0, flow_r != 5'h1f};
      end
   end
   // timing, parking and hand-over relations
   property p_gbuf; $rose(i_gbuf_clk) |-> ##[3:7] $rose(o_gbuf_clk); endproperty
   a_gbuf: assert property (p_gbuf) else $error("buffer lost an input rise");
   property p_rhigh; $rose(o_rmux_clk) |=> o_rmux_clk [*3]; endproperty
   a_rhigh: assert property (p_rhigh) else $error("short high phase on mux");
   property p_flow; $fell(o_fmux_clk) |=> !o_fmux_clk [*3]; endproperty
   a_flow: assert property (p_flow) else $error("short low phase on mux");
   property p_rsrc; $changed(o_rmux_src) |-> !o_rmux_clk && !$past(o_rmux_clk); endproperty
   a_rsrc: assert property (p_rsrc) else $error("rise mux switched while high");
   property p_fsrc; $changed(o_fmux_src) |-> o_fmux_clk && $past(o_fmux_clk); endproperty
   a_fsrc: assert property (p_fsrc) else $error("fall mux switched while low");
   property p_rhold; o_rmux_hold |-> !o_rmux_clk; endproperty
   a_rhold: assert property (p_rhold) else $error("rise mux not parked low");
   property p_fhold; o_fmux_hold |-> o_fmux_clk; endproperty
   a_fhold: assert property (p_fhold) else $error("fall mux not parked high");
   property p_rgate; (rlow_r >= 5'h14) |-> !o_rgate_clk; endproperty
   a_rgate: assert property (p_rgate) else $error("disabled rise gate not low");
   property p_fgate; (flow_r >= 5'h14) |-> o_fgate_clk; endproperty
   a_fgate: assert property (p_fgate) else $error("disabled fall gate not high");
endmodule // gfcm_props

bind gfcm_top gfcm_props i_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_gbuf_clk(i_gbuf_clk),
   .i_rgate_clock_gate_enable(i_rgate_clock_gate_enable), .i_fgate_clock_gate_enable(i_fgate_clock_gate_enable),
   .o_rmux_clk(o_rmux_clk), .o_rmux_src(o_rmux_src), .o_rmux_hold(o_rmux_hold), .o_fmux_clk(o_fmux_clk),
   .o_fmux_src(o_fmux_src), .o_fmux_hold(o_fmux_hold), .o_rgate_clk(o_rgate_clk), .o_fgate_clk(o_fgate_clk),
   .o_gbuf_clk(o_gbuf_clk));

// ---- verif/testbench.sv ----
// testbench: drives selects and enables of the clock mux and gate block, judges output clocks
// assumes three clock source models feed all clock inputs, phases in whole core cycles
`timescale 1ns/1ps
module testbench;
   // stimulus, observed outputs and monitor state
   logic       i_core_clk = 1'b0;
   logic       i_rst_n = 1'b0;
   logic       rsel = 1'b0, fsel = 1'b0, ren = 1'b1, fen = 1'b1;
   logic       qr = 1'b0, qf = 1'b0, qg = 1'b0, qh = 1'b0, qb = 1'b0;
   logic [7:0] cr = 8'h00, cf = 8'h00, pr = 8'h00, pf = 8'h00, nr = 8'h00, nf = 8'h00, nb = 8'h00;
   wire        ca, cb, cc, rclk, rsrc, rhold, fclk, fsrc, fhold, gr, gf, gb;
   integer     error_cnt = 0, samples_checked = 0, i;
   always #4 i_core_clk = ~i_core_clk;
   // clock sources: periods of 8, 12 and 10 core cycles
   gfcm_clk_src i_src_a (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .o_clk(ca));
   gfcm_clk_src #(.HI(5), .LO(7)) i_src_b (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .o_clk(cb));
   gfcm_clk_src #(.HI(6), .LO(4)) i_src_c (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .o_clk(cc));
   gfcm_top i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rmux_clk_low_sel(ca), .i_rmux_clk_high_sel(cb),
      .i_rmux_clock_select(rsel), .i_fmux_clk_low_sel(cc), .i_fmux_clk_high_sel(ca), .i_fmux_clock_select(fsel),
      .i_rgate_clk(ca), .i_rgate_clock_gate_enable(ren), .i_fgate_clk(ca), .i_fgate_clock_gate_enable(fen),
      .i_gbuf_clk(ca), .o_rmux_clk(rclk), .o_rmux_src(rsrc), .o_rmux_hold(rhold), .o_fmux_clk(fclk),
      .o_fmux_src(fsrc), .o_fmux_hold(fhold), .o_rgate_clk(gr), .o_fgate_clk(gf), .o_gbuf_clk(gb));
   // edge monitor: rise-to-rise periods of the muxes, pulse counts of the buffers
   always @(posedge i_core_clk) begin
      {qr, qf, qg, qh, qb} <= {rclk, fclk, gr, gf, gb};
      cr <= (rclk & ~qr) ? 8'h01 : cr + 8'h01;
      cf <= (fclk & ~qf) ? 8'h01 : cf + 8'h01;
      if (rclk & ~qr) pr <= cr;
      if (fclk & ~qf) pf <= cf;
      nr <= nr + {7'h00, gr & ~qg};
      nf <= nf + {7'h00, ~gf & qh};
      nb <= nb + {7'h00, gb & ~qb};
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      samples_checked = samples_checked + 1;
      if (s !== e) begin
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
         error_cnt = error_cnt + 1;
      end
   endtask
   task results;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // reset levels of the clock outputs, then both muxes on the low-select input with no hold
   task t_reset;
      repeat (10) @(posedge i_core_clk);
      #1 chk({3'h0, rclk, fclk, gr, gf, gb}, 8'h0a);
      repeat (10) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      #1 chk({4'h0, rsrc, fsrc, rhold, fhold}, 8'h00);
   endtask
   // switch both muxes to the high-select input and back, judging source and output period
   task t_mux;
      for (int k = 1; k >= 0; k--) begin
         @(posedge i_core_clk) {rsel, fsel} <= {k[0], k[0]};
         for (i = 0; i < 100 && rsrc !== k[0]; i++) @(posedge i_core_clk);
         repeat (40) @(posedge i_core_clk);
         #1 chk({6'h00, rsrc, fsrc}, {6'h00, k[0], k[0]});
         chk(pr, k[0] ? 8'h0c : 8'h08);
         chk(pf, k[0] ? 8'h08 : 8'h0a);
         chk({6'h00, rhold, fhold}, 8'h00);
      end
   endtask
   // gates off then on, counting pulses over 40 cycles (five input periods)
   task t_gate;
      logic [7:0] mr, mf, mb;
      for (int k = 0; k <= 1; k++) begin
         @(posedge i_core_clk) {ren, fen} <= {k[0], k[0]};
         repeat (30) @(posedge i_core_clk);
         {mr, mf, mb} = {nr, nf, nb};
         repeat (40) @(posedge i_core_clk);
         chk(nr - mr, k[0] ? 8'h05 : 8'h00);
         chk(nf - mf, k[0] ? 8'h05 : 8'h00);
         chk(nb - mb, 8'h05);
         if (k == 0) #1 chk({6'h00, gr, gf}, 8'h01);
      end
   endtask
   initial begin
      t_reset;
      t_mux;
      t_gate;
      results;
   end
   // watchdog: the sequence needs about 300 core cycles
   initial begin
      #40000;
      error_cnt = error_cnt + 1;
      results;
   end
endmodule // testbench
